// ==== rtl/tcsw_clkdiv.sv ====
// Divider that derives a nominal 32 kHz slow clock from the reference clock.
// Assumes ref_tick marks each reference edge, sampled in the hclk domain.
`timescale 1ns/1ns
`default_nettype none
module tcsw_clkdiv
    import tcsw_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ref_tick,
    input  wire logic run,
    output logic      slow_tick
);
    logic [8:0] cnt_q;
    logic       cnt_wrap;

    // Wrap when the half-period count ends; halted counter gives no ticks
    assign cnt_wrap  = run && ref_tick && (cnt_q == TCSW_DIV_LAST);
    assign slow_tick = cnt_wrap;

    // Count reference edges only while the reference domain is powered
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= 9'h000;
        else if (!run)
            cnt_q <= 9'h000;
        else if (ref_tick)
            cnt_q <= cnt_wrap ? 9'h000 : cnt_q + 9'h001;
    end
endmodule
`default_nettype wire

// ==== rtl/tcsw_pkg.sv ====
// Package for the trickle clock select and wake gating block.
// Assumes a single 100 MHz bus clock and 32-bit AHB-Lite register access.
package tcsw_pkg;
    // Register byte offsets
    localparam logic [7:0]  TCSW_OFF_SLOW_CFG  = 8'hF0;
    localparam logic [7:0]  TCSW_OFF_WAKE_STS  = 8'hF4;
    localparam logic [7:0]  TCSW_OFF_WAKE_MASK = 8'hF8;
    localparam logic [7:0]  TCSW_OFF_PWR_STS   = 8'hFC;
    // Field positions and reset values
    localparam int          TCSW_ABSENT_BIT    = 0;
    localparam logic [7:0]  TCSW_SLOW_CFG_RST  = 8'h00;
    localparam logic [17:0] TCSW_MASK_RST      = 18'h00000;
    localparam int          TCSW_NUM_SRC       = 18;
    // Wake status bit layout: ring1, ring2, kbd, mouse, key, group a[7:0], group b[3:0]
    localparam int          TCSW_BIT_RING1     = 0;
    localparam int          TCSW_BIT_RING2     = 1;
    localparam int          TCSW_BIT_KBD       = 2;
    localparam int          TCSW_BIT_MOUSE     = 3;
    localparam int          TCSW_BIT_KEY       = 4;
    localparam int          TCSW_BIT_GRPA      = 5;
    localparam int          TCSW_BIT_GRPB      = 13;
    // Derived slow clock: reference 14.318 MHz divided to about 32 kHz
    localparam int          TCSW_REF_KHZ       = 14318;
    localparam int          TCSW_SLOW_KHZ      = 32;
    localparam int          TCSW_DIV_HALF      = TCSW_REF_KHZ / (2 * TCSW_SLOW_KHZ);
    localparam logic [8:0]  TCSW_DIV_LAST      = 9'(TCSW_DIV_HALF - 1);
    // AHB encodings
    localparam logic [1:0]  TCSW_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  TCSW_HTRANS_SEQ    = 2'h3;
endpackage

// ==== rtl/tcsw_top.sv ====
// Slow clock selection, wake event gathering and host decode gating.
// Assumes trickle and main power states arrive as synchronous levels.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module tcsw_top
    import tcsw_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        trickle_por_n,
    input  wire logic        internal_power_good,
    input  wire logic        main_supply_on,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        slow_clock_tick,
    input  wire logic        reference_tick,
    input  wire logic        ring_indicator_one,
    input  wire logic        ring_indicator_two,
    input  wire logic        kbd_data_activity,
    input  wire logic        mouse_data_activity,
    input  wire logic        key_match,
    input  wire logic [7:0]  wake_input_group_a,
    input  wire logic [3:0]  wake_input_group_b,
    input  wire logic        general_pin_24_in,
    input  wire logic [11:0] wake_pin_out_req,
    output logic [11:0]      wake_pin_oe,
    output logic             debounce_tick,
    output logic             blink_tick,
    output logic             key_wake_tick,
    output logic             wake_event_out_n,
    output logic             wake_event_out_oe,
    output logic             irq
);
    logic [7:0]  slow_cfg_q;
    logic [17:0] sts_q;
    logic [17:0] sts_d;
    logic [17:0] mask_q;
    logic [17:0] src_q;
    logic [17:0] src_now;
    logic [17:0] src_rise;
    logic        ph_valid_q;
    logic        ph_write_q;
    logic [7:0]  ph_addr_q;
    logic [31:0] hrdata_q;
    logic        absent;
    logic        derived_tick;
    logic        key_tick;
    logic        addr_take;
    logic        wr_cfg;
    logic        wr_mask;
    logic        rd_sts;
    logic [31:0] rd_mux;
    logic        wake_pending;

    // Offset match on the low address byte only; the interconnect owns the
    // upper bits, so the register window repeats through the whole slot
    function automatic logic tcsw_hit
    (
        input logic [7:0] addr,
        input logic [7:0] off
    );
        return addr == off;
    endfunction

    // Decode of the address phase; power good low blocks every decode
    assign addr_take = hsel && hready && internal_power_good &&
                       (htrans == TCSW_HTRANS_NONSEQ || htrans == TCSW_HTRANS_SEQ);
    // Writes land in the data phase, the first cycle in which hwdata stands
    assign wr_cfg    = ph_valid_q && ph_write_q && tcsw_hit(ph_addr_q, TCSW_OFF_SLOW_CFG);
    assign wr_mask   = ph_valid_q && ph_write_q && tcsw_hit(ph_addr_q, TCSW_OFF_WAKE_MASK);
    assign rd_sts    = addr_take && !hwrite && tcsw_hit(haddr[7:0], TCSW_OFF_WAKE_STS);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // Address phase capture for the following data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q  <= 8'h00;
        end
        else if (hready)
        begin
            ph_valid_q <= addr_take;
            ph_write_q <= hwrite;
            ph_addr_q  <= haddr[7:0];
        end
    end

    // Read data mux; unmapped offsets read zero
    always_comb
    begin
        if (tcsw_hit(haddr[7:0], TCSW_OFF_SLOW_CFG))
            rd_mux = {24'h000000, slow_cfg_q};
        else if (tcsw_hit(haddr[7:0], TCSW_OFF_WAKE_STS))
            rd_mux = {14'h0000, sts_q};
        else if (tcsw_hit(haddr[7:0], TCSW_OFF_WAKE_MASK))
            rd_mux = {14'h0000, mask_q};
        else if (tcsw_hit(haddr[7:0], TCSW_OFF_PWR_STS))
            rd_mux = {29'h00000000, main_supply_on, internal_power_good, absent};
        else
            rd_mux = 32'h00000000;
    end

    // Read data registered in the address phase, valid in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h00000000;
        else if (addr_take && !hwrite)
            hrdata_q <= rd_mux;
    end

    // Slow clock config lives on the trickle reset, not the bus reset
    always_ff @(posedge hclk or negedge trickle_por_n)
    begin
        if (!trickle_por_n)
            slow_cfg_q <= TCSW_SLOW_CFG_RST;
        else if (wr_cfg)
            slow_cfg_q <= hwdata[7:0];
    end

    assign absent = slow_cfg_q[TCSW_ABSENT_BIT];

    // Derived clock runs only while the reference has main power
    // Bus reset suffices for the divider: its count is lost with main power anyway
    tcsw_clkdiv u_div
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ref_tick  (reference_tick),
        .run       (main_supply_on),
        .slow_tick (derived_tick)
    );

    // Key wake falls back to derived clock; debounce and blink never do
    assign key_tick      = absent ? derived_tick : slow_clock_tick;
    assign key_wake_tick = key_tick;
    assign debounce_tick = absent ? 1'b0 : slow_clock_tick;
    assign blink_tick    = absent ? 1'b0 : slow_clock_tick;

    // Sources gathered; pin 24 has no path into wake logic
    // Bit 17 has no source and is tied low so the status word keeps its width
    assign src_now = {1'b0, wake_input_group_b, wake_input_group_a,
                      key_match && key_tick, mouse_data_activity,
                      kbd_data_activity, ring_indicator_two, ring_indicator_one};
    assign src_rise = src_now & ~src_q;

    // Pin drivers main powered: forced to input on trickle only
    assign wake_pin_oe = main_supply_on ? wake_pin_out_req : 12'h000;

    // Sticky status, set wins over the read clear
    // so an event that meets the clearing read is never lost
    assign sts_d = (rd_sts ? 18'h00000 : sts_q) | src_rise;

    // Wake logic stays on trickle reset so it lives without power good
    always_ff @(posedge hclk or negedge trickle_por_n)
    begin
        if (!trickle_por_n)
        begin
            src_q  <= 18'h00000;
            sts_q  <= 18'h00000;
            mask_q <= TCSW_MASK_RST;
        end
        else
        begin
            src_q  <= src_now;
            sts_q  <= sts_d;
            if (wr_mask)
                mask_q <= hwdata[17:0];
        end
    end

    // Open-drain wake output pulled low while an enabled event stands
    // Data is held low and only the enable moves: the pin can never drive high
    assign wake_pending      = |(sts_q & mask_q);
    assign wake_event_out_n  = 1'b0;
    assign wake_event_out_oe = wake_pending;
    assign irq               = wake_pending;

    // Checks
    a_cfg_write: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        wr_cfg |=> slow_cfg_q == $past(hwdata[7:0]))
        else $error("config write lost");
    a_cfg_hold: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        !wr_cfg |=> $stable(slow_cfg_q))
        else $error("config changed without write");
    a_ext_clock: assert property (@(posedge hclk) disable iff (!hresetn)
        !absent |-> key_wake_tick == slow_clock_tick && debounce_tick == slow_clock_tick)
        else $error("external clock not selected");
    a_derived_key: assert property (@(posedge hclk) disable iff (!hresetn)
        absent |-> key_wake_tick == derived_tick)
        else $error("derived clock not selected");
    a_no_fallback: assert property (@(posedge hclk) disable iff (!hresetn)
        absent |-> !debounce_tick && !blink_tick)
        else $error("debounce or blink on derived clock");
    a_key_dead: assert property (@(posedge hclk) disable iff (!hresetn)
        (absent && !main_supply_on) |-> !key_wake_tick)
        else $error("key wake clocked without power");
    a_ref_stop: assert property (@(posedge hclk) disable iff (!hresetn)
        !main_supply_on |-> !derived_tick)
        else $error("reference logic ran unpowered");
    a_no_decode: assert property (@(posedge hclk) disable iff (!hresetn)
        !internal_power_good |=> !ph_valid_q)
        else $error("decode without power good");
    a_wake_drive: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        (src_rise[TCSW_BIT_RING1] && mask_q[TCSW_BIT_RING1]) |=> wake_event_out_oe)
        else $error("wake not driven");
    a_pin24_none: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        ($rose(general_pin_24_in) && sts_q == 18'h00000 && $stable(src_now)) |=>
        sts_q == 18'h00000)
        else $error("pin 24 raised wake");
    a_input_only: assert property (@(posedge hclk) disable iff (!hresetn)
        !main_supply_on |-> wake_pin_oe == 12'h000)
        else $error("wake pin driven on trickle");
    c_wake: cover property (@(posedge hclk) disable iff (!trickle_por_n)
        $rose(wake_event_out_oe));
    c_absent: cover property (@(posedge hclk) disable iff (!hresetn)
        absent && key_wake_tick);
    c_clear: cover property (@(posedge hclk) disable iff (!trickle_por_n) rd_sts && |sts_q);

    // Clock selection and reference gating
    a_blink_ext: assert property (@(posedge hclk) disable iff (!hresetn)
        !absent |-> blink_tick == slow_clock_tick)
        else $error("blink not on external clock");
    a_key_gated: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        src_rise[TCSW_BIT_KEY] |-> key_wake_tick)
        else $error("key event without key clock");
    a_div_gap: assert property (@(posedge hclk) disable iff (!hresetn)
        derived_tick |=> !derived_tick [*8])
        else $error("derived clock pulses too close");
    a_cfg_keep: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        !hresetn |=> $stable(slow_cfg_q))
        else $error("bus reset touched config");

    // Host gating and pin drivers
    a_read_stale: assert property (@(posedge hclk) disable iff (!hresetn)
        !internal_power_good |=> $stable(hrdata))
        else $error("read decoded without power good");
    a_pin_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        main_supply_on |-> wake_pin_oe == wake_pin_out_req)
        else $error("wake pin request lost on main power");

    // Sticky status, mask and wake output
    a_sts_sticky: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        !rd_sts |=> (sts_q & $past(sts_q)) == $past(sts_q))
        else $error("status bit lost without read");
    a_set_wins: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        (|src_rise) |=> (sts_q & $past(src_rise)) == $past(src_rise))
        else $error("event not captured in status");
    a_read_clear: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        (rd_sts && src_rise == 18'h00000) |=> sts_q == 18'h00000)
        else $error("status not cleared by read");
    a_mask_write: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        wr_mask |=> mask_q == $past(hwdata[17:0]))
        else $error("mask write lost");
    a_mask_hold: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        !wr_mask |=> $stable(mask_q))
        else $error("mask changed without write");
    a_wake_level: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        ((sts_q & mask_q) != 18'h00000) |-> wake_event_out_oe && irq && !wake_event_out_n)
        else $error("enabled event not driven");
    a_wake_release: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        ((sts_q & mask_q) == 18'h00000) |-> !wake_event_out_oe && !irq)
        else $error("wake driven with no event");
    a_pg_low_wake: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        (!internal_power_good && !wr_mask && src_rise[TCSW_BIT_RING2] &&
         mask_q[TCSW_BIT_RING2]) |=> wake_event_out_oe)
        else $error("wake lost without power good");
    a_grp_b_wake: assert property (@(posedge hclk) disable iff (!trickle_por_n)
        (!wr_mask && src_rise[TCSW_BIT_GRPB] && mask_q[TCSW_BIT_GRPB]) |=> wake_event_out_oe)
        else $error("group b pin did not wake");

    // Scenarios worth seeing: wake with host off, derived clock in use
    c_pg_wake: cover property (@(posedge hclk) disable iff (!trickle_por_n)
        !internal_power_good && $rose(wake_event_out_oe));
    c_derived: cover property (@(posedge hclk) disable iff (!hresetn)
        absent && main_supply_on && derived_tick);
endmodule
`default_nettype wire

// ==== verification/tcsw_chipset_model.sv ====
// Chipset side of the wake line: resolves the open-drain wake pin.
// Assumes the board pull-up holds the line high when nobody pulls it.
`timescale 1ns/1ns
`default_nettype none
module tcsw_chipset_model
(
    input  wire logic wake_event_out_n,
    input  wire logic wake_event_out_oe,
    output logic      wake_line_n
);
    // Pull-up wins whenever the device releases the pin
    assign wake_line_n = wake_event_out_oe ? wake_event_out_n : 1'b1;
endmodule
`default_nettype wire

// ==== verification/trickle_clock_select_wake_gating_tb.sv ====
// Self-checking bench for the slow clock select and wake gating block.
// Assumes a zero-wait AHB-Lite slave and one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module trickle_clock_select_wake_gating_tb;
    import tcsw_pkg::*;
    logic        hclk, hresetn, trickle_por_n, pg, ms, hsel, hwrite, slow, rt, p24;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [16:0] src;
    logic [11:0] req, oe;
    logic        hreadyout, hresp, deb, blk, kwt, wn, woe, irq, line_n;
    int          n_errors, n_compared, k;
    tcsw_top dut_u (.hclk(hclk), .hresetn(hresetn), .trickle_por_n(trickle_por_n),
        .internal_power_good(pg), .main_supply_on(ms), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .slow_clock_tick(slow), .reference_tick(rt), .ring_indicator_one(src[0]),
        .ring_indicator_two(src[1]), .kbd_data_activity(src[2]),
        .mouse_data_activity(src[3]), .key_match(src[4]),
        .wake_input_group_a(src[12:5]), .wake_input_group_b(src[16:13]),
        .general_pin_24_in(p24), .wake_pin_out_req(req), .wake_pin_oe(oe),
        .debounce_tick(deb), .blink_tick(blk), .key_wake_tick(kwt),
        .wake_event_out_n(wn), .wake_event_out_oe(woe), .irq(irq));
    tcsw_chipset_model chip_u (.wake_event_out_n(wn), .wake_event_out_oe(woe),
        .wake_line_n(line_n));
    // Clock generator
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Compare and count; unknowns never match
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One single AHB transfer; waits on hreadyout, never assumes a latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= TCSW_HTRANS_NONSEQ;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", hresp, 0);
    endtask
    // Step n+1 cycles, with a slow clock pulse in the first
    task automatic step(input int n);
        slow <= 1'b1;
        @(posedge hclk);
        slow <= 1'b0;
        repeat (n) @(posedge hclk);
    endtask
    // Count derived key clock pulses over a span longer than one divider period
    task automatic count_kwt(output int c);
        c = 0;
        rt <= 1'b1;
        repeat (470) @(posedge hclk) c += int'(kwt === 1'b1);
        rt <= 1'b0;
    endtask
    initial
    begin
        {hresetn, trickle_por_n, hsel, hwrite, slow, rt, p24} = '0;
        {pg, ms} = 2'b11;
        {haddr, hwdata, htrans, src, req} = '0;
        repeat (6) @(posedge hclk);
        {hresetn, trickle_por_n} <= 2'b11;
        @(posedge hclk);
        bus(0, TCSW_OFF_SLOW_CFG, 0);  check("cfg_rst", rd, 0);
        bus(0, 8'hE0, 0);              check("unmapped", rd, 0);
        // Flag clear: all three consumers follow the external slow clock
        slow <= 1'b1;
        #1 check("ext_ticks", {deb, blk, kwt}, 3'b111);
        @(posedge hclk) slow <= 1'b0;
        bus(1, TCSW_OFF_SLOW_CFG, 1);
        bus(0, TCSW_OFF_PWR_STS, 0);  check("pwr_sts", rd, 32'h7);
        slow <= 1'b1;
        #1 check("no_fallback", {deb, blk, kwt}, 3'b000);
        @(posedge hclk) slow <= 1'b0;
        count_kwt(k);  check("derived", k != 0, 1);
        ms <= 1'b0;
        count_kwt(k);  check("no_ref", k, 0);
        req <= 12'hFFF;
        #1 check("pin_oe_off", oe, 0);
        @(posedge hclk) ms <= 1'b1;
        #1 check("pin_oe_on", oe, 32'hFFF);
        // Bus reset spares the trickle register; trickle reset does not
        @(posedge hclk) hresetn <= 1'b0;
        @(posedge hclk) hresetn <= 1'b1;
        @(posedge hclk) bus(0, TCSW_OFF_SLOW_CFG, 0);  check("keep", rd, 1);
        pg <= 1'b0;
        bus(1, TCSW_OFF_SLOW_CFG, 0);
        bus(0, 8'hE0, 0);  check("pg_rd", rd, 1);
        pg <= 1'b1;
        bus(0, TCSW_OFF_SLOW_CFG, 0);  check("pg_drop", rd, 1);
        @(posedge hclk) trickle_por_n <= 1'b0;
        @(posedge hclk) trickle_por_n <= 1'b1;
        @(posedge hclk) bus(0, TCSW_OFF_SLOW_CFG, 0);  check("por", rd, 0);
        bus(0, TCSW_OFF_WAKE_MASK, 0);  check("mask_rst", rd, 0);
        // Masked event sets status but leaves the line released
        src[0] <= 1'b1;
        step(3);  check("masked", {irq, line_n}, 2'b01);
        bus(0, TCSW_OFF_WAKE_STS, 0);  check("sts_m", rd, 1);
        src[0] <= 1'b0;
        bus(1, TCSW_OFF_WAKE_MASK, 32'h1FFFF);
        bus(0, TCSW_OFF_WAKE_MASK, 0);  check("mask_wr", rd, 32'h1FFFF);
        // Each source in turn with power good low; read clears status
        for (int i = 0; i < 17; i++)
        begin
            pg <= 1'b0;
            src[i] <= 1'b1;
            step(3);  check("wake", {irq, line_n}, 2'b10);
            pg <= 1'b1;
            bus(0, TCSW_OFF_WAKE_STS, 0);  check("sts", rd, 32'h1 << i);
            src[i] <= 1'b0;
            step(2);  check("clear", irq, 0);
        end
        p24 <= 1'b1;
        step(3);  check("pin24", {irq, line_n}, 2'b01);
        print_verdict();
    end
    // Watchdog: the sequence needs well under 5000 cycles
    initial
    begin
        #200000;
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
